// ==== src/lrd_pkg.sv ====
// Shared constants, register indices and types of the readout display controller.
package lrd_pkg;
    // Timing: a half-second enable tick drives blinking and message cycling.
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned TICK_MS = 500;
    localparam int unsigned TICK_CYC = TICK_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned DONE_S = 20;
    localparam int unsigned DONE_TICKS = DONE_S * 1000 / TICK_MS;
    localparam int unsigned PHASE_TICKS = 4;
    // Display geometry.
    localparam int unsigned ROWS = 2;
    localparam int unsigned COLS = 8;
    localparam int unsigned VALUE_DIGITS = 5;
    localparam int unsigned GLYPH_CHARS = 5;
    localparam int unsigned GLYPH_LINES = 8;
    localparam int unsigned GLYPH_REGS = GLYPH_CHARS * GLYPH_LINES;
    localparam int unsigned GLYPH_PIX = 5;
    // Register values with a fixed meaning.
    localparam logic [15:0] CUSTOM_UNIT = 16'h0039;
    localparam logic [15:0] DP_AUTO = 16'h0000;
    localparam logic [15:0] SRC_RESET = 16'h1D5B;
    // Register indices; the byte address is four times the index.
    localparam logic [15:0] IDX_UNIT_MAIN = 16'h0FB4;
    localparam logic [15:0] IDX_DP = 16'h0FB5;
    localparam logic [15:0] IDX_UNIT_TWO = 16'h0FB7;
    localparam logic [15:0] IDX_SRC = 16'h0FB8;
    localparam logic [15:0] IDX_GLYPH = 16'h1130;
    localparam logic [15:0] IDX_IRQ_STS = 16'h1200;
    localparam logic [15:0] IDX_IRQ_EN = 16'h1201;
    localparam logic [15:0] IDX_IRQ_CLR = 16'h1202;
    localparam logic [15:0] IDX_STATE = 16'h1203;
    // Interrupt bit positions.
    localparam int unsigned IRQ_W = 3;
    localparam int unsigned IRQ_KEY = 0;
    localparam int unsigned IRQ_DONE = 1;
    localparam int unsigned IRQ_OVF = 2;
    // Lower row functions in key order.
    typedef enum logic [2:0] {F_UNIT, F_TIME, F_DATE, F_BAR, F_SECOND} lrd_func_t;
    typedef enum logic [1:0] {TOP_VALUE, TOP_UNDER, TOP_OVER} lrd_top_t;
    typedef enum logic [1:0] {MSG_NONE, MSG_RESTORE, MSG_DONE} lrd_msg_t;
    // Instrument state reported to the display.
    typedef struct packed {
        logic store_ready;
        logic store_unmounted;
        logic store_wprot;
        logic store_full;
        logic show_max;
        logic show_min;
        logic under;
        logic over;
    } lrd_meas_t;
    // What the panel shows.
    typedef struct packed {
        lrd_top_t top;
        logic [2:0] digits;
        logic dp_auto;
        logic picto_store;
        logic picto_max;
        logic picto_min;
        lrd_func_t func;
        logic unit_custom;
        logic two_units;
        lrd_msg_t msg;
        logic msg_show;
    } lrd_disp_t;
endpackage : lrd_pkg

// ==== src/lrd_display_ctrl.sv ====
// Display controller of a two-row character readout, with its APB register file.
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - Drive a backlit display of two rows, eight characters each.
// - Upper row shows main value with five digits plus pictograms.
// - Storage pictogram steady when ready, blinking when unmounted, protected or full.
// - Max or min pictogram shown steadily while that extreme is displayed.
// - Decimal-point register zero selects automatic precision.
// - Lower overflow shows V signs, upper overflow its own sign pattern.
// - Keys step lower row: unit, time, date, bar graph, second value.
// - Second value register number comes from the source register.
// - Selected lower-row function is kept in non-volatile storage.
// - Service messages cycle; restore-done for 20 s, restore-needed until restored.
// - Custom unit has five cells of eight rows, forty registers.
// - Main unit select value 57 shows the custom glyph unit.
// - Glyph row register holds five pixels, bit 4 leftmost.
// - Both units shown only in second-value mode.
module lrd_display_ctrl #(
    parameter int unsigned TICK_CYC_P = lrd_pkg::TICK_CYC
) (
    // Clock and reset.
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // APB slave.
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [15:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Front-panel keys, raw pins.
    input wire logic key_next_in,
    input wire logic key_prev_in,
    // Instrument state and service events.
    input wire lrd_pkg::lrd_meas_t meas_in,
    input wire logic restore_need_in,
    input wire logic restore_done_in,
    // Non-volatile copy of the lower-row function.
    input wire logic [2:0] nv_func_in,
    output logic nv_save_out,
    output logic [2:0] nv_func_out,
    // Glyph row read port for the character generator.
    input wire logic [2:0] glyph_char_in,
    input wire logic [2:0] glyph_line_in,
    output logic [4:0] glyph_row_out,
    // Display content.
    output lrd_pkg::lrd_disp_t disp_out,
    output logic [15:0] unit_main_out,
    output logic [15:0] unit_two_out,
    output logic [15:0] second_src_out,
    output logic blink_out,
    // Interrupt.
    output logic irq_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // State.

    // The whole state of the block; the display is two rows of eight cells.
    typedef struct packed {
        logic [15:0] unit_main;
        logic [15:0] dp_sel;
        logic [15:0] unit_two;
        logic [15:0] src_reg;
        logic [lrd_pkg::GLYPH_REGS-1:0][lrd_pkg::GLYPH_PIX-1:0] glyph;
        logic [lrd_pkg::IRQ_W-1:0] irq_sts;
        logic [lrd_pkg::IRQ_W-1:0] irq_en;
        logic [31:0] rdata;
        logic slverr;
        lrd_pkg::lrd_func_t func;
        logic nv_loaded;
        logic nv_save;
        logic [2:0] sy_next;
        logic [2:0] sy_prev;
        logic lv_next;
        logic lv_prev;
        logic [31:0] div;
        logic tick;
        logic blink;
        logic [1:0] phase_cnt;
        logic phase;
        logic [7:0] done_cnt;
        logic done_act;
        logic ovf_prev;
        logic [4:0] glyph_row;
        lrd_pkg::lrd_disp_t disp;
    } lrd_state_t;

    lrd_state_t s_reg;
    lrd_state_t s_next;
    logic [15:0] idx;
    logic [15:0] goff;
    logic g_hit;
    logic hit;
    logic [31:0] rd;
    logic agree_next;
    logic agree_prev;
    logic rise_next;
    logic rise_prev;
    logic [lrd_pkg::IRQ_W-1:0] ev;
    logic [lrd_pkg::IRQ_W-1:0] clr;
    logic blink_cond;

    ////////////////////////////////////////////////////////////////////////////////
    // Decode and events.

    // Register index decode; only aligned words are mapped.
    always_comb begin
        idx = {2'b00, paddr_in[15:2]};
        goff = idx - lrd_pkg::IDX_GLYPH;
        g_hit = (idx >= lrd_pkg::IDX_GLYPH) && (goff < 16'(lrd_pkg::GLYPH_REGS));
        hit = (paddr_in[1:0] == 2'h0) && (g_hit || idx == lrd_pkg::IDX_UNIT_MAIN
            || idx == lrd_pkg::IDX_DP || idx == lrd_pkg::IDX_UNIT_TWO
            || idx == lrd_pkg::IDX_SRC || idx == lrd_pkg::IDX_IRQ_STS
            || idx == lrd_pkg::IDX_IRQ_EN || idx == lrd_pkg::IDX_IRQ_CLR
            || idx == lrd_pkg::IDX_STATE);
        rd = 32'h0;
        if (g_hit) begin
            rd = {27'h0, s_reg.glyph[goff[5:0]]};
        end else if (idx == lrd_pkg::IDX_UNIT_MAIN) begin
            rd = {16'h0, s_reg.unit_main};
        end else if (idx == lrd_pkg::IDX_DP) begin
            rd = {16'h0, s_reg.dp_sel};
        end else if (idx == lrd_pkg::IDX_UNIT_TWO) begin
            rd = {16'h0, s_reg.unit_two};
        end else if (idx == lrd_pkg::IDX_SRC) begin
            rd = {16'h0, s_reg.src_reg};
        end else if (idx == lrd_pkg::IDX_IRQ_STS) begin
            rd = {29'h0, s_reg.irq_sts};
        end else if (idx == lrd_pkg::IDX_IRQ_EN) begin
            rd = {29'h0, s_reg.irq_en};
        end else if (idx == lrd_pkg::IDX_STATE) begin
            rd = {25'h0, s_reg.func, s_reg.blink, s_reg.phase, s_reg.done_act, s_reg.nv_loaded};
        end
    end

    // A key counts once the second and third synchroniser stages agree.
    always_comb begin
        agree_next = s_reg.sy_next[1] == s_reg.sy_next[2];
        agree_prev = s_reg.sy_prev[1] == s_reg.sy_prev[2];
        rise_next = agree_next && s_reg.sy_next[2] && !s_reg.lv_next;
        rise_prev = agree_prev && s_reg.sy_prev[2] && !s_reg.lv_prev;
        blink_cond = meas_in.store_unmounted || meas_in.store_wprot || meas_in.store_full;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state.

    // All behaviour of the block in one pass over the state.
    always_comb begin
        s_next = s_reg;
        s_next.tick = 1'b0;
        s_next.nv_save = 1'b0;
        ev = '0;
        clr = '0;
        // Half-second enable from the clock divider, toggling the blink phase.
        if (s_reg.div == 32'(TICK_CYC_P - 1)) begin
            s_next.div = 32'h0;
            s_next.tick = 1'b1;
        end else begin
            s_next.div = s_reg.div + 32'h1;
        end
        if (s_reg.tick) begin
            s_next.blink = ~s_reg.blink;
            s_next.phase_cnt = s_reg.phase_cnt + 2'h1;
            if (s_reg.phase_cnt == 2'(lrd_pkg::PHASE_TICKS - 1)) begin
                s_next.phase = ~s_reg.phase;
            end
        end
        // Restore-done message lives for a fixed number of ticks.
        if (restore_done_in) begin
            s_next.done_act = 1'b1;
            s_next.done_cnt = 8'h0;
        end else if (s_reg.done_act && s_reg.tick) begin
            if (s_reg.done_cnt == 8'(lrd_pkg::DONE_TICKS - 1)) begin
                s_next.done_act = 1'b0;
                ev[lrd_pkg::IRQ_DONE] = 1'b1;
            end else begin
                s_next.done_cnt = s_reg.done_cnt + 8'h1;
            end
        end
        // Key synchronisers and their agreed levels.
        s_next.sy_next = {s_reg.sy_next[1:0], key_next_in};
        s_next.sy_prev = {s_reg.sy_prev[1:0], key_prev_in};
        if (agree_next) begin
            s_next.lv_next = s_reg.sy_next[2];
        end
        if (agree_prev) begin
            s_next.lv_prev = s_reg.sy_prev[2];
        end
        // Lower-row function: restored once after reset, then stepped by keys.
        if (!s_reg.nv_loaded) begin
            s_next.nv_loaded = 1'b1;
            if (nv_func_in <= 3'(lrd_pkg::F_SECOND)) begin
                s_next.func = lrd_pkg::lrd_func_t'(nv_func_in);
            end else begin
                s_next.func = lrd_pkg::F_UNIT;
            end
        end else if (rise_next != rise_prev) begin
            if (rise_next) begin
                s_next.func = (s_reg.func == lrd_pkg::F_SECOND) ? lrd_pkg::F_UNIT
                    : lrd_pkg::lrd_func_t'(3'(s_reg.func + 3'h1));
            end else begin
                s_next.func = (s_reg.func == lrd_pkg::F_UNIT) ? lrd_pkg::F_SECOND
                    : lrd_pkg::lrd_func_t'(3'(s_reg.func - 3'h1));
            end
            s_next.nv_save = 1'b1;
            ev[lrd_pkg::IRQ_KEY] = 1'b1;
        end
        // Overflow onset raises an event.
        s_next.ovf_prev = meas_in.under || meas_in.over;
        if ((meas_in.under || meas_in.over) && !s_reg.ovf_prev) begin
            ev[lrd_pkg::IRQ_OVF] = 1'b1;
        end
        // APB: read data is latched in setup, writes land in the access phase.
        if (psel_in && !penable_in) begin
            s_next.rdata = rd;
            s_next.slverr = !hit;
        end
        if (psel_in && penable_in && pwrite_in && hit) begin
            if (g_hit) begin
                s_next.glyph[goff[5:0]] = pwdata_in[4:0];
            end else if (idx == lrd_pkg::IDX_UNIT_MAIN) begin
                s_next.unit_main = pwdata_in[15:0];
            end else if (idx == lrd_pkg::IDX_DP) begin
                s_next.dp_sel = pwdata_in[15:0];
            end else if (idx == lrd_pkg::IDX_UNIT_TWO) begin
                s_next.unit_two = pwdata_in[15:0];
            end else if (idx == lrd_pkg::IDX_SRC) begin
                s_next.src_reg = pwdata_in[15:0];
            end else if (idx == lrd_pkg::IDX_IRQ_EN) begin
                s_next.irq_en = pwdata_in[lrd_pkg::IRQ_W-1:0];
            end else if (idx == lrd_pkg::IDX_IRQ_CLR) begin
                clr = pwdata_in[lrd_pkg::IRQ_W-1:0];
            end
        end
        // Sticky status: a new event wins over a clear in the same cycle.
        s_next.irq_sts = (s_reg.irq_sts & ~clr) | ev;
        // Glyph row lookup for the character generator.
        if (glyph_char_in < 3'(lrd_pkg::GLYPH_CHARS)) begin
            s_next.glyph_row = s_reg.glyph[{glyph_char_in, glyph_line_in}];
        end else begin
            s_next.glyph_row = 5'h0;
        end
        // Upper row content; lower overflow has priority.
        if (meas_in.under) begin
            s_next.disp.top = lrd_pkg::TOP_UNDER;
        end else if (meas_in.over) begin
            s_next.disp.top = lrd_pkg::TOP_OVER;
        end else begin
            s_next.disp.top = lrd_pkg::TOP_VALUE;
        end
        s_next.disp.digits = 3'(lrd_pkg::VALUE_DIGITS);
        s_next.disp.dp_auto = s_reg.dp_sel == lrd_pkg::DP_AUTO;
        s_next.disp.picto_store = blink_cond ? s_reg.blink : meas_in.store_ready;
        s_next.disp.picto_max = meas_in.show_max;
        s_next.disp.picto_min = meas_in.show_min;
        // Lower row content and units.
        s_next.disp.func = s_reg.func;
        s_next.disp.unit_custom = s_reg.unit_main == lrd_pkg::CUSTOM_UNIT;
        s_next.disp.two_units = s_reg.func == lrd_pkg::F_SECOND;
        // Service message alternates with the values; the measured display stays live.
        if (s_reg.done_act) begin
            s_next.disp.msg = lrd_pkg::MSG_DONE;
        end else if (restore_need_in) begin
            s_next.disp.msg = lrd_pkg::MSG_RESTORE;
        end else begin
            s_next.disp.msg = lrd_pkg::MSG_NONE;
        end
        s_next.disp.msg_show = (s_reg.done_act || restore_need_in) && s_reg.phase;
    end

    // State register; reset loads constants only.
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            s_reg <= '0;
            s_reg.src_reg <= lrd_pkg::SRC_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    // Zero-wait APB answer and registered data.
    assign pready_out = psel_in && penable_in;
    assign pslverr_out = psel_in && penable_in && s_reg.slverr;
    assign prdata_out = s_reg.rdata;
    assign irq_out = |(s_reg.irq_sts & s_reg.irq_en);
    assign nv_save_out = s_reg.nv_save;
    assign nv_func_out = s_reg.func;
    assign glyph_row_out = s_reg.glyph_row;
    assign disp_out = s_reg.disp;
    assign unit_main_out = s_reg.unit_main;
    assign unit_two_out = s_reg.unit_two;
    assign second_src_out = s_reg.src_reg;
    assign blink_out = s_reg.blink;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);

    // A debounced next-key press after the restore step.
    sequence s_next_press;
        s_reg.nv_loaded && rise_next && !rise_prev;
    endsequence

    // The lower row then shows a different function, with the save strobe up.
    sequence s_step_seen;
        ##1 (s_reg.func != $past(s_reg.func)) && s_reg.nv_save;
    endsequence

    AST_KEY_STEP: assert property (s_next_press |-> s_step_seen)
        else $error("key press did not step the lower row");

    // A debounced previous-key press after the restore step.
    sequence s_prev_press;
        s_reg.nv_loaded && rise_prev && !rise_next;
    endsequence
    AST_KEY_BACK: assert property (s_prev_press |-> s_step_seen)
        else $error("previous key did not step the lower row");
    AST_NV_SAVE: assert property ($past(s_reg.nv_loaded) && $changed(s_reg.func)
        |-> s_reg.nv_save && nv_func_out == s_reg.func)
        else $error("function change not saved");
    AST_STORE: assert property (meas_in.store_ready && !blink_cond
        |=> disp_out.picto_store)
        else $error("storage pictogram not steady");
    AST_STORE_BLINK: assert property (blink_cond
        |=> disp_out.picto_store == $past(s_reg.blink))
        else $error("storage pictogram not blinking");
    AST_MAX: assert property (meas_in.show_max |=> disp_out.picto_max)
        else $error("max pictogram missing");
    AST_MIN: assert property (meas_in.show_min |=> disp_out.picto_min)
        else $error("min pictogram missing");
    AST_DP_AUTO: assert property (s_reg.dp_sel == lrd_pkg::DP_AUTO |=> disp_out.dp_auto)
        else $error("automatic precision not selected");
    AST_UNDER: assert property (meas_in.under |=> disp_out.top == lrd_pkg::TOP_UNDER)
        else $error("lower overflow signs missing");
    AST_OVER: assert property (!meas_in.under && meas_in.over
        |=> disp_out.top == lrd_pkg::TOP_OVER)
        else $error("upper overflow sign missing");
    AST_VALUE: assert property (!meas_in.under && !meas_in.over
        |=> disp_out.top == lrd_pkg::TOP_VALUE)
        else $error("value not shown without overflow");
    AST_TWO_UNITS: assert property (disp_out.two_units
        |-> $past(s_reg.func) == lrd_pkg::F_SECOND)
        else $error("two units outside second-value mode");
    AST_CUSTOM: assert property (s_reg.unit_main == lrd_pkg::CUSTOM_UNIT
        |=> disp_out.unit_custom)
        else $error("custom unit not selected");
    AST_GLYPH: assert property (glyph_char_in < 3'(lrd_pkg::GLYPH_CHARS)
        |=> glyph_row_out == $past(s_reg.glyph[{glyph_char_in, glyph_line_in}]))
        else $error("glyph row read wrong");
    AST_BLINK: assert property (s_reg.tick |=> s_reg.blink != $past(s_reg.blink))
        else $error("blink did not toggle on tick");
    AST_DONE_LEN: assert property (s_reg.done_act
        |-> s_reg.done_cnt < 8'(lrd_pkg::DONE_TICKS))
        else $error("restore-done message overran");
    AST_MSG_SHOW: assert property (disp_out.msg_show
        |-> disp_out.msg != lrd_pkg::MSG_NONE)
        else $error("message flagged with no message active");
    AST_IRQ_SET: assert property (ev != '0 |=> (s_reg.irq_sts & $past(ev)) == $past(ev))
        else $error("event lost against clear");

endmodule : lrd_display_ctrl

`default_nettype wire

// ==== src/lrd_display_ctrl_note_placeholder.sv ====
// Intentionally empty compilation unit kept for compile order.
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ==== bench/lrd_panel_model.sv ====
// Partner model: front-panel keys and the non-volatile store of the lower-row function.
`timescale 1ns/1ns
`default_nettype none
module lrd_panel_model (
    // Clock.
    input wire logic sys_clk_in,
    // Key requests from the bench.
    input wire logic press_next_in,
    input wire logic press_prev_in,
    // Key pins.
    output logic key_next_out,
    output logic key_prev_out,
    // Non-volatile store.
    input wire logic nv_save_in,
    input wire logic [2:0] nv_func_in,
    output logic [2:0] nv_func_out
);
    logic [3:0] cnt_reg = 4'h0;
    logic which_reg = 1'b0;
    logic [2:0] store_reg = 3'h0;
    // A press holds the pin six cycles, then keeps it low six more so the release is seen.
    always @(posedge sys_clk_in) begin
        if (cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
        end else if (press_next_in || press_prev_in) begin
            cnt_reg <= 4'hC;
            which_reg <= press_prev_in;
        end
    end
    assign key_next_out = (cnt_reg > 4'h6) && !which_reg;
    assign key_prev_out = (cnt_reg > 4'h6) && which_reg;
    // The store survives resets, as a supply loss would leave it.
    always @(posedge sys_clk_in) begin
        if (nv_save_in) begin
            store_reg <= nv_func_in;
        end
    end
    assign nv_func_out = store_reg;
endmodule : lrd_panel_model
`default_nettype wire

// ==== bench/test_lrd_display_ctrl.sv ====
// Self-checking testbench of the readout display controller.
`timescale 1ns/1ns
`default_nettype none
module test_lrd_display_ctrl;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [15:0] paddr = 16'h0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, kn, kp, pn = 1'b0, pp = 1'b0, nv_save, blink, irq;
    logic rneed = 1'b0, rdone = 1'b0;
    logic [2:0] nvi, nvo, gch = 3'h0, gln = 3'h0;
    logic [4:0] grow;
    logic [15:0] um, ut, src;
    lrd_pkg::lrd_meas_t meas = '0;
    lrd_pkg::lrd_disp_t disp;
    logic [32:0] rq[$];
    logic [2:0] nq[$];
    logic [15:0] v[4];
    logic [4:0] gv[40];
    int n_fail = 0, checked = 0, seed = 32'h9FD2, cp, cm, cb;
    always #5 clk = ~clk;
    lrd_display_ctrl #(.TICK_CYC_P(4)) u_dut (.sys_clk_in(clk), .rst_in(rst), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .key_next_in(kn),
        .key_prev_in(kp), .meas_in(meas), .restore_need_in(rneed), .restore_done_in(rdone),
        .nv_func_in(nvi), .nv_save_out(nv_save), .nv_func_out(nvo), .glyph_char_in(gch),
        .glyph_line_in(gln), .glyph_row_out(grow), .disp_out(disp), .unit_main_out(um),
        .unit_two_out(ut), .second_src_out(src), .blink_out(blink), .irq_out(irq));
    lrd_panel_model u_panel (.sys_clk_in(clk), .press_next_in(pn), .press_prev_in(pp),
        .key_next_out(kn), .key_prev_out(kp), .nv_save_in(nv_save), .nv_func_in(nvo),
        .nv_func_out(nvi));
    ////////////////////////////////////////////////////////////////////////////////
    // Compares one value and counts it.
    task check(input logic [32:0] seen, input logic [32:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Prints the counts and the verdict, then ends the run.
    task test_done();
        $display("comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done
    // One APB transfer; a read notes its expected error flag and data.
    task apb(input logic w, input logic [15:0] idx, input logic [31:0] d, input logic [32:0] e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= idx << 2;
        pwdata <= d;
        if (!w) rq.push_back(e);
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Asks the panel for a key press and notes the function it must lead to.
    task press(input logic prev, input logic [2:0] f);
        @(posedge clk);
        nq.push_back(f);
        if (prev) pp <= 1'b1;
        else pn <= 1'b1;
        @(posedge clk);
        pn <= 1'b0;
        pp <= 1'b0;
        repeat (16) @(posedge clk);
        #1;
    endtask : press
    // Lets registered outputs land before they are looked at.
    task settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle
    // Counts changes of the store pictogram, the message flag and the blink phase.
    task watch(input int n);
        logic a, b, c;
        cp = 0; cm = 0; cb = 0;
        repeat (n) begin
            a = disp.picto_store; b = disp.msg_show; c = blink;
            @(posedge clk);
            #1;
            cp += int'(a != disp.picto_store);
            cm += int'(b != disp.msg_show);
            cb += int'(c != blink);
        end
    endtask : watch
    ////////////////////////////////////////////////////////////////////////////////
    // Result watcher: takes the oldest note whenever a read or a save appears.
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) check({pslverr, prdata}, rq.pop_front());
        if (nv_save === 1'b1) check(33'(nvo), (nq.size() > 0) ? 33'(nq.pop_front()) : 33'h7);
    end
    // Watchdog against a hang.
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        test_done();
    end
    // Main sequence.
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        apb(0, lrd_pkg::IDX_SRC, 0, 33'(lrd_pkg::SRC_RESET));
        apb(0, lrd_pkg::IDX_UNIT_MAIN, 0, 33'h0);
        apb(0, 16'h0FB6, 0, 33'h100000000);
        for (int i = 0; i < 4; i++) begin
            v[i] = 16'($random(seed));
            apb(1, lrd_pkg::IDX_UNIT_MAIN + 16'(i + (i > 1)), {16'h0, v[i]}, 0);
            apb(0, lrd_pkg::IDX_UNIT_MAIN + 16'(i + (i > 1)), 0, {17'h0, v[i]});
        end
        check(33'({um, ut}), 33'({v[0], v[2]}));
        check(33'(src), 33'(v[3]));
        apb(1, lrd_pkg::IDX_UNIT_MAIN, 32'(lrd_pkg::CUSTOM_UNIT), 0);
        apb(1, lrd_pkg::IDX_DP, 32'(lrd_pkg::DP_AUTO), 0);
        settle(3);
        check(33'({disp.unit_custom, disp.dp_auto, disp.digits}),
            33'({2'b11, 3'(lrd_pkg::VALUE_DIGITS)}));
        apb(1, lrd_pkg::IDX_UNIT_MAIN, 32'h00000038, 0);
        apb(1, lrd_pkg::IDX_DP, 32'h00000003, 0);
        settle(3);
        check(33'({disp.unit_custom, disp.dp_auto}), 33'h0);
        $display("test registers done");
        for (int i = 0; i < 40; i++) begin
            gv[i] = 5'($random(seed));
            apb(1, lrd_pkg::IDX_GLYPH + 16'(i), 32'(gv[i]), 0);
        end
        apb(0, lrd_pkg::IDX_GLYPH + 16'h0027, 0, 33'(gv[39]));
        for (int i = 0; i < 41; i++) begin
            gch <= 3'(i / 8);
            gln <= 3'(i % 8);
            settle(2);
            check(33'(grow), (i < 40) ? 33'(gv[i]) : 33'h0);
        end
        $display("test glyphs done");
        apb(1, lrd_pkg::IDX_IRQ_EN, 32'h00000001, 0);
        for (int i = 1; i < 6; i++) begin
            press(0, 3'(i % 5));
            check(33'({disp.func, disp.two_units}), 33'({3'(i % 5), i == 4}));
        end
        check(33'(irq), 33'h1);
        apb(1, lrd_pkg::IDX_IRQ_CLR, 32'h00000001, 0);
        apb(1, lrd_pkg::IDX_IRQ_EN, 32'h00000000, 0);
        press(1, 3'h4);
        apb(0, lrd_pkg::IDX_IRQ_STS, 0, 33'h1);
        check(33'({irq, disp.func}), 33'(lrd_pkg::F_SECOND));
        apb(1, lrd_pkg::IDX_IRQ_CLR, 32'h00000007, 0);
        rst <= 1'b1;
        settle(2);
        rst <= 1'b0;
        settle(4);
        check(33'(disp.func), 33'(lrd_pkg::F_SECOND));
        $display("test keys done");
        apb(1, lrd_pkg::IDX_IRQ_EN, 32'h00000004, 0);
        meas <= 8'h03;
        settle(3);
        check(33'({disp.top, irq}), 33'({lrd_pkg::TOP_UNDER, 1'b1}));
        meas <= 8'h01;
        settle(3);
        check(33'(disp.top), 33'(lrd_pkg::TOP_OVER));
        apb(1, lrd_pkg::IDX_IRQ_CLR, 32'h00000004, 0);
        meas <= 8'h88;
        settle(2);
        watch(16);
        check(33'({cp, disp.picto_store, disp.picto_max, disp.picto_min}), 33'h6);
        for (int i = 0; i < 3; i++) begin
            meas <= 8'hC4 >> i;
            watch(40);
            check(33'({cp > 1, disp.picto_min}), 33'({1'b1, i == 0}));
            check(33'(cb >= 9 && cb <= 10), 33'h1);
        end
        $display("test display done");
        @(posedge clk);
        rdone <= 1'b1;
        @(posedge clk);
        rdone <= 1'b0;
        settle(3);
        check(33'(disp.msg), 33'(lrd_pkg::MSG_DONE));
        watch(64);
        check(33'(cm >= 2), 33'h1);
        settle(80);
        check(33'(disp.msg), 33'(lrd_pkg::MSG_DONE));
        settle(20);
        check(33'(disp.msg), 33'(lrd_pkg::MSG_NONE));
        // Overflow onset from the pictogram scenarios is still pending beside the message end.
        apb(0, lrd_pkg::IDX_IRQ_STS, 0, 33'h6);
        rneed <= 1'b1;
        settle(200);
        check(33'(disp.msg), 33'(lrd_pkg::MSG_RESTORE));
        $display("test messages done");
        test_done();
    end
endmodule : test_lrd_display_ctrl
`default_nettype wire
